// File: pkg/tcu_timer_consts.vh
`ifndef TCU_TIMER_CONSTS_VH
`define TCU_TIMER_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TCU_OFS_CONTROL 5'h00
`define TCU_OFS_COUNT 5'h04
`define TCU_OFS_COMPARE 5'h08
`define TCU_OFS_STATUS 5'h0c
`define TCU_OFS_FLAG 5'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TCU_CTL_FORCE 7
`define TCU_CTL_WGM0 6
`define TCU_CTL_COM_HI 5
`define TCU_CTL_COM_LO 4
`define TCU_CTL_WGM1 3
`define TCU_CTL_CS_HI 2
`define TCU_CTL_CS_LO 0
`define TCU_CTL_RESET 8'h00

// ----------------------------------------
// Status fields
// ----------------------------------------
`define TCU_ST_ASYNC 3
`define TCU_ST_CNT_PEND 2
`define TCU_ST_CMP_PEND 1
`define TCU_ST_CTL_PEND 0

// ----------------------------------------
// Waveform modes, output modes, clock selects
// ----------------------------------------
`define TCU_WGM_NORMAL 2'h0
`define TCU_WGM_PCPWM 2'h1
`define TCU_WGM_CTC 2'h2
`define TCU_WGM_FAST 2'h3
`define TCU_COM_OFF 2'h0
`define TCU_COM_TOGGLE 2'h1
`define TCU_COM_CLEAR 2'h2
`define TCU_COM_SET 2'h3
`define TCU_CS_STOP 3'h0
`define TCU_CS_DIV1 3'h1
`define TCU_CS_DIV8 3'h2
`define TCU_CS_DIV32 3'h3
`define TCU_CS_DIV64 3'h4
`define TCU_CS_DIV128 3'h5
`define TCU_CS_DIV256 3'h6
`define TCU_CS_DIV1024 3'h7

// Prescaler tap masks: tick when the masked bits are all ones
`define TCU_MASK_DIV8 10'h007
`define TCU_MASK_DIV32 10'h01f
`define TCU_MASK_DIV64 10'h03f
`define TCU_MASK_DIV128 10'h07f
`define TCU_MASK_DIV256 10'h0ff
`define TCU_MASK_DIV1024 10'h3ff

`define TCU_COUNT_MAX 8'hff
`define TCU_COUNT_BOTTOM 8'h00

`endif

// File: rtl/tcu_timer8.v
// Behaviour
// R01 - Nonzero output mode hands the pin over to the compare output.
// R02 - Pin driver enabled only while the pin direction bit selects output.
// R03 - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// R04 - Fast PWM: 10 clear on match/set at bottom, 11 inverse, 01 reserved.
// R05 - Fast PWM, compare equals TOP, upper bit set: match ignored, bottom acts.
// R06 - Phase-correct: 10 clears up-counting, sets down-counting; 11 inverse.
// R07 - Phase-correct, compare equals TOP, upper bit set: action done at TOP.
// R08 - Clock select: stop, divide 1, 8, 32, 64, 128, 256, 1024.
// R09 - Counter register readable and writable directly by software.
// R10 - Counter write blocks compare match on the next timer tick.
// R11 - Compare value continuously matched against count; sets flag, drives pin.
// R12 - Async select bit 3 picks system clock or crystal input as source.
// R13 - Software reinitialises timer registers after changing async select.
// R14 - Async counter write sets busy bit 2 until value reaches counter.
// R15 - Async compare write sets busy bit 1 until transferred.
// R16 - Async control write sets busy bit 0 until transferred.
// R17 - Software never writes a register while its busy bit is set.
// R18 - Counter reads live count; compare and control read holding registers.
// R19 - Async holding value transfers after two crystal input rising edges.
// R20 - Match flag set on match, cleared by vector ack or writing one.
// R21 - Clock select stop holds the count with no matches or pin changes.
`timescale 1ns/1ps
`default_nettype none
`include "tcu_timer_consts.vh"

module tcu_timer8 #(
	parameter PRE_W = 10
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Avalon-MM slave
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	// Timer clock source
	input wire crystal_osc_input,
	// Pin and port logic
	input wire port_data,
	input wire port_dir,
	output reg compare_output_pin,
	output reg compare_output_pin_oe,
	// Match flag
	input wire vector_ack,
	output wire compare_match_flag
);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	reg ack_q;
	wire req = avs_read | avs_write;
	wire wr_take = avs_write & ack_q;
	assign avs_waitrequest = req & ~ack_q;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	wire wr_ctl = wr_take & (avs_address == `TCU_OFS_CONTROL);
	wire wr_cnt = wr_take & (avs_address == `TCU_OFS_COUNT);
	wire wr_cmp = wr_take & (avs_address == `TCU_OFS_COMPARE);
	wire wr_st = wr_take & (avs_address == `TCU_OFS_STATUS);
	wire wr_flag = wr_take & (avs_address == `TCU_OFS_FLAG);
	wire [7:0] wdata = avs_writedata[7:0];

	// ----------------------------------------
	// Source clock and async transfers
	// ----------------------------------------
	reg async_q;
	reg osc_q;
	wire osc_rise = crystal_osc_input & ~osc_q;
	wire src_pulse = async_q ? osc_rise : 1'b1; // R12

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			async_q <= 1'b0;
			osc_q <= 1'b0;
		end else begin
			osc_q <= crystal_osc_input;
			if (wr_st) begin
				async_q <= wdata[`TCU_ST_ASYNC]; // R12
			end
		end
	end

	// Index 2 counter, 1 compare, 0 control, as in the status layout
	wire [2:0] wr_sel = {wr_cnt, wr_cmp, wr_ctl};
	wire [2:0] pend;
	wire [2:0] xfer;
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_pend
			reg pend_q;
			reg edge_q;
			// Second crystal rising edge completes the transfer
			assign xfer[i] = pend_q & osc_rise & edge_q; // R19
			assign pend[i] = pend_q;
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					pend_q <= 1'b0;
					edge_q <= 1'b0;
				end else if (wr_sel[i] & async_q) begin
					pend_q <= 1'b1; // R14 R15 R16
					edge_q <= 1'b0;
				end else if (xfer[i]) begin
					pend_q <= 1'b0; // R14 R15 R16
					edge_q <= 1'b0;
				end else if (pend_q & osc_rise) begin
					edge_q <= 1'b1;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Holding and active registers
	// ----------------------------------------
	reg [6:0] ctl_hold_q;
	reg [6:0] ctl_q;
	reg force_pend_q;
	reg [7:0] cmp_hold_q;
	reg [7:0] cmp_q;
	reg [7:0] cnt_hold_q;
	localparam [7:0] CTL_RST = `TCU_CTL_RESET;

	// Sync writes land at once, save compare in PWM modes; async ones wait for the transfer
	wire ctl_load = (wr_ctl & ~async_q) | xfer[0];
	wire cmp_load = (wr_cmp & ~async_q) | xfer[1];
	wire cnt_load = (wr_cnt & ~async_q) | xfer[2]; // R09
	wire force_now = (wr_ctl & ~async_q & wdata[`TCU_CTL_FORCE]) |
		(xfer[0] & force_pend_q);
	// Strobe acts on the mode being written, not the one it replaces
	wire [1:0] force_com = async_q ?
		ctl_hold_q[`TCU_CTL_COM_HI:`TCU_CTL_COM_LO] :
		wdata[`TCU_CTL_COM_HI:`TCU_CTL_COM_LO];
	wire force_pwm = async_q ? ctl_hold_q[`TCU_CTL_WGM0] :
		wdata[`TCU_CTL_WGM0];

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctl_hold_q <= CTL_RST[6:0];
			ctl_q <= CTL_RST[6:0];
			force_pend_q <= 1'b0;
			cmp_hold_q <= `TCU_COUNT_BOTTOM;
			cnt_hold_q <= `TCU_COUNT_BOTTOM;
		end else begin
			if (wr_ctl) begin
				ctl_hold_q <= wdata[6:0];
				force_pend_q <= wdata[`TCU_CTL_FORCE];
			end
			if (wr_cmp) begin
				cmp_hold_q <= wdata;
			end
			if (wr_cnt) begin
				cnt_hold_q <= wdata;
			end
			if (wr_ctl & ~async_q) begin
				ctl_q <= wdata[6:0];
			end else if (xfer[0]) begin
				ctl_q <= ctl_hold_q;
			end
		end
	end

	wire [1:0] wgm = {ctl_q[`TCU_CTL_WGM1], ctl_q[`TCU_CTL_WGM0]};
	wire [1:0] com = ctl_q[`TCU_CTL_COM_HI:`TCU_CTL_COM_LO];
	wire [2:0] cs = ctl_q[`TCU_CTL_CS_HI:`TCU_CTL_CS_LO];
	wire [7:0] cnt_src = async_q ? cnt_hold_q : wdata;
	wire [7:0] cmp_src = async_q ? cmp_hold_q : wdata;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	reg [PRE_W-1:0] pre_q;
	reg [PRE_W-1:0] tap;
	reg tick;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_q <= {PRE_W{1'b0}};
		end else if (src_pulse) begin
			pre_q <= pre_q + 1'b1;
		end
	end

	always @* begin
		tap = {PRE_W{1'b0}};
		case (cs)
		`TCU_CS_DIV8: tap = `TCU_MASK_DIV8; // R08
		`TCU_CS_DIV32: tap = `TCU_MASK_DIV32;
		`TCU_CS_DIV64: tap = `TCU_MASK_DIV64;
		`TCU_CS_DIV128: tap = `TCU_MASK_DIV128;
		`TCU_CS_DIV256: tap = `TCU_MASK_DIV256;
		`TCU_CS_DIV1024: tap = `TCU_MASK_DIV1024;
		default: tap = {PRE_W{1'b0}};
		endcase
		// Stopped select yields no tick at all
		tick = src_pulse & (cs != `TCU_CS_STOP) &
			((pre_q & tap) == tap); // R08 R21
	end

	// ----------------------------------------
	// Counter and waveform
	// ----------------------------------------
	reg [7:0] cnt_q;
	reg [7:0] cnt_d;
	reg down_q;
	reg down_d;
	reg block_q;
	reg oc_q;
	reg oc_d;
	reg [7:0] cmp_d;
	reg flag_q;

	wire is_pwm = wgm[0];
	wire [7:0] top = (wgm == `TCU_WGM_CTC) ? cmp_q : `TCU_COUNT_MAX;
	wire match = (cnt_q == cmp_q) & ~block_q; // R10 R11
	wire top_case = com[1] & (cmp_q == `TCU_COUNT_MAX); // R05 R07
	wire at_max = (cnt_q == `TCU_COUNT_MAX);
	wire match_evt = tick & match;

	always @* begin
		cnt_d = cnt_q;
		down_d = down_q;
		oc_d = oc_q;
		cmp_d = cmp_q;
		if (tick) begin
			case (wgm)
			`TCU_WGM_FAST: begin
				cnt_d = cnt_q + 8'h01;
				if (at_max) begin
					// Compare buffer refreshes at bottom
					cmp_d = cmp_hold_q;
					if (com == `TCU_COM_CLEAR) begin
						oc_d = 1'b1; // R04 R05
					end else if (com == `TCU_COM_SET) begin
						oc_d = 1'b0; // R04 R05
					end
				end else if (match & ~top_case) begin
					if (com == `TCU_COM_CLEAR) begin
						oc_d = 1'b0; // R04
					end else if (com == `TCU_COM_SET) begin
						oc_d = 1'b1; // R04
					end
				end
			end
			`TCU_WGM_PCPWM: begin
				if (~down_q & at_max) begin
					down_d = 1'b1;
					cnt_d = cnt_q - 8'h01;
					cmp_d = cmp_hold_q;
				end else if (down_q & (cnt_q == `TCU_COUNT_BOTTOM)) begin
					down_d = 1'b0;
					cnt_d = cnt_q + 8'h01;
				end else if (down_q) begin
					cnt_d = cnt_q - 8'h01;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
				if (top_case & at_max & ~down_q) begin
					oc_d = (com == `TCU_COM_CLEAR); // R07
				end else if (match & ~top_case & com[1]) begin
					// Lower bit picks polarity, direction picks edge
					oc_d = down_q ^ com[0]; // R06
				end
			end
			default: begin
				cnt_d = (cnt_q == top) ? `TCU_COUNT_BOTTOM :
					cnt_q + 8'h01;
				if (match) begin
					case (com)
					`TCU_COM_TOGGLE: oc_d = ~oc_q; // R03
					`TCU_COM_CLEAR: oc_d = 1'b0; // R03
					`TCU_COM_SET: oc_d = 1'b1; // R03
					default: oc_d = oc_q;
					endcase
				end
			end
			endcase
		end
		// Forced compare acts only in non-PWM modes
		if (force_now & ~force_pwm) begin
			case (force_com)
			`TCU_COM_TOGGLE: oc_d = ~oc_q;
			`TCU_COM_CLEAR: oc_d = 1'b0;
			`TCU_COM_SET: oc_d = 1'b1;
			default: oc_d = oc_q;
			endcase
		end
		if (cmp_load) begin
			// Non-PWM modes take the compare value at once
			if (~is_pwm | ~async_q) begin
				cmp_d = is_pwm ? cmp_q : cmp_src;
			end
		end
		if (cnt_load) begin
			cnt_d = cnt_src; // R09
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= `TCU_COUNT_BOTTOM;
			down_q <= 1'b0;
			block_q <= 1'b0;
			oc_q <= 1'b0;
			cmp_q <= `TCU_COUNT_BOTTOM;
			flag_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			down_q <= down_d;
			oc_q <= oc_d;
			cmp_q <= cmp_d;
			// Write arms the block; the next tick consumes it
			if (cnt_load) begin
				block_q <= 1'b1; // R10
			end else if (tick) begin
				block_q <= 1'b0; // R10
			end
			// Set beats a clear in the same cycle
			if (match_evt) begin
				flag_q <= 1'b1; // R11 R20
			end else if (vector_ack | (wr_flag & wdata[0])) begin
				flag_q <= 1'b0; // R20
			end
		end
	end

	assign compare_match_flag = flag_q;

	// ----------------------------------------
	// Pin mux
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			compare_output_pin <= 1'b0;
			compare_output_pin_oe <= 1'b0;
		end else begin
			compare_output_pin <= (com != `TCU_COM_OFF) ? oc_q :
				port_data; // R01
			compare_output_pin_oe <= port_dir; // R02
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & ~ack_q) begin
			case (avs_address)
			`TCU_OFS_CONTROL: avs_readdata <= {25'h0000000, ctl_hold_q}; // R18
			`TCU_OFS_COUNT: avs_readdata <= {24'h000000, cnt_q}; // R18
			`TCU_OFS_COMPARE: avs_readdata <= {24'h000000, cmp_hold_q}; // R18
			`TCU_OFS_STATUS: avs_readdata <= {28'h0000000, async_q, pend};
			`TCU_OFS_FLAG: avs_readdata <= {31'h00000000, flag_q};
			default: avs_readdata <= 32'h00000000;
			endcase
		end
	end

endmodule

`default_nettype wire

// File: dv/tcu_timer8_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_timer8_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bus
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Pin
	input wire logic port_data,
	input wire logic port_dir,
	input wire logic compare_output_pin,
	input wire logic compare_output_pin_oe,
	input wire logic compare_match_flag
);
	// Mirror of output mode; sync writes only, async ones land late
	logic [1:0] com_q;
	logic async_q;
	wire wr_done = avs_write && !avs_waitrequest;
	wire rd_done = avs_read && !avs_waitrequest;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			com_q <= 2'h0;
			async_q <= 1'b0;
		end else if (wr_done) begin
			if (avs_address == 5'h00 && !async_q)
				com_q <= avs_writedata[5:4];
			if (avs_address == 5'h0c)
				async_q <= avs_writedata[3];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_wait_first_cycle: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
	a_wait_one_cycle: assert property (avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
	a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
	a_upper_bits_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0) else $error("upper bits");
	a_force_reads_zero: assert property (rd_done && avs_address == 5'h00 |-> !avs_readdata[7]) else $error("force bit");
	a_unmapped_zero: assert property (rd_done && avs_address > 5'h10 |-> avs_readdata == 32'h0) else $error("unmapped");
	a_oe_follows_dir: assert property (1'b1 |=> compare_output_pin_oe == $past(port_dir)) else $error("oe");
	a_pin_port_mode: assert property (!$past(async_q) && $past(com_q) == 2'h0 |-> compare_output_pin == $past(port_data)) else $error("port");
	cover property (wr_done && avs_address == 5'h0c);
	cover property (compare_match_flag);
	cover property (rd_done && avs_address == 5'h00);
endmodule
bind tcu_timer8 tcu_timer8_properties u_props (.ref_clk(ref_clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .port_data(port_data),
	.port_dir(port_dir), .compare_output_pin(compare_output_pin),
	.compare_output_pin_oe(compare_output_pin_oe),
	.compare_match_flag(compare_match_flag));
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr_en = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] wd = 32'h0;
	logic pd = 1'b0;
	logic pdir = 1'b0;
	logic vack = 1'b0;
	logic [3:0] xc = 4'h0;
	logic [7:0] q;
	wire [31:0] rdat;
	wire wreq, pin, oe, flag;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	int hi;
	int dv[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
	logic [7:0] ctl[6] = '{8'h69, 8'h79, 8'h61, 8'h71, 8'h69, 8'h61};
	logic [7:0] cv[6] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hff, 8'hff};
	int ex[6] = '{259, 765, 256, 764, 1020, 1020};
	logic [1:0] com[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	tcu_timer8 dut (.ref_clk(ref_clk), .rst(rst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr_en), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(wreq),
		.crystal_osc_input(xc[3]), .port_data(pd), .port_dir(pdir),
		.compare_output_pin(pin), .compare_output_pin_oe(oe),
		.vector_ack(vack), .compare_match_flag(flag));
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	// Free-running crystal, 16 system cycles a period
	always @(posedge ref_clk) begin
		xc <= xc + 4'h1;
		cyc++;
		if (cyc == 80000) begin
			errors++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		wr_en <= w;
		rd <= !w;
		adr <= a;
		wd <= {24'h0, d};
		@(posedge ref_clk);
		while (wreq !== 1'b0) begin
			@(posedge ref_clk);
		end
		q = rdat[7:0];
		wr_en <= 1'b0;
		rd <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rng(input logic [15:0] got, input int lo, input int hi);
		checks++;
		if (^got === 1'bx || got < lo || got > hi) begin
			errors++;
			$display("[ERR] %0t got %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		cmp(q, exp);
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) rdc(5'(4 * i), 8'h00);
		cmp({7'h0, oe}, 8'h00);
		acc(1'b1, 5'h04, 8'h5a);
		rdc(5'h04, 8'h5a);
		repeat (50) @(posedge ref_clk);
		rdc(5'h04, 8'h5a);
		for (int s = 1; s < 8; s++) begin
			acc(1'b1, 5'h04, 8'h00);
			acc(1'b1, 5'h00, {5'h0, 3'(s)});
			repeat (20 * dv[s] - 2) @(posedge ref_clk);
			acc(1'b1, 5'h00, 8'h00);
			acc(1'b0, 5'h04, 8'h00);
			rng({8'h0, q}, 19, 22);
		end
		acc(1'b1, 5'h10, 8'h01);
		acc(1'b1, 5'h08, 8'h20);
		acc(1'b1, 5'h04, 8'h30);
		acc(1'b1, 5'h00, 8'h01);
		acc(1'b1, 5'h04, 8'h20);
		rdc(5'h10, 8'h00);
		repeat (300) @(posedge ref_clk);
		rdc(5'h10, 8'h01);
		cmp({7'h0, flag}, 8'h01);
		acc(1'b1, 5'h10, 8'h01);
		rdc(5'h10, 8'h00);
		repeat (300) @(posedge ref_clk);
		rdc(5'h10, 8'h01);
		vack <= 1'b1;
		@(posedge ref_clk);
		vack <= 1'b0;
		rdc(5'h10, 8'h00);
		cmp({7'h0, flag}, 8'h00);
		pdir <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, 5'h00, {2'h2, com[i], 4'h0});
			@(posedge ref_clk);
			cmp({7'h0, pin}, {7'h0, ~i[0]});
		end
		cmp({7'h0, oe}, 8'h01);
		acc(1'b1, 5'h00, 8'h00);
		pd <= 1'b1;
		repeat (2) @(posedge ref_clk);
		cmp({7'h0, pin}, 8'h01);
		pd <= 1'b0;
		for (int m = 0; m < 6; m++) begin
			acc(1'b1, 5'h08, cv[m]);
			acc(1'b1, 5'h00, ctl[m]);
			repeat (600) @(posedge ref_clk);
			hi = 0;
			repeat (1020) begin
				@(posedge ref_clk);
				if (pin === 1'b1)
					hi++;
			end
			rng(16'(hi), ex[m] - 8, ex[m] + 8);
		end
		acc(1'b1, 5'h00, 8'h00);
		acc(1'b1, 5'h0c, 8'h08);
		acc(1'b1, 5'h04, 8'h33);
		acc(1'b1, 5'h08, 8'h44);
		acc(1'b1, 5'h00, 8'h00);
		rdc(5'h0c, 8'h0f);
		rdc(5'h08, 8'h44);
		repeat (40) @(posedge ref_clk);
		rdc(5'h0c, 8'h08);
		rdc(5'h04, 8'h33);
		acc(1'b1, 5'h00, 8'h01);
		repeat (40) @(posedge ref_clk);
		rdc(5'h0c, 8'h08);
		acc(1'b1, 5'h00, 8'h00);
		repeat (40) @(posedge ref_clk);
		acc(1'b0, 5'h04, 8'h00);
		rng({8'h0, q}, 16'h34, 16'h38);
		tally_and_finish();
	end
endmodule
`default_nettype wire
